// ==== pkg/tpw_pkg.sv ====
// Package: constants for the three-phase PWM timing core
`default_nettype none
package tpw_pkg;
  // ***************
  // Widths
  // ***************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OEC_W  = 9;
  localparam int unsigned MPW_W  = 10;

  // ***************
  // Register map
  // ***************
  localparam logic [11:0] OFS_PERIOD = 12'h000;
  localparam logic [11:0] OFS_DEAD   = 12'h004;
  localparam logic [11:0] OFS_MINPW  = 12'h008;
  localparam logic [11:0] OFS_SYNCW  = 12'h00c;
  localparam logic [11:0] OFS_DUTY_A = 12'h010;
  localparam logic [11:0] OFS_DUTY_B = 12'h014;
  localparam logic [11:0] OFS_DUTY_C = 12'h018;
  localparam logic [11:0] OFS_OEC    = 12'h01c;
  localparam logic [11:0] OFS_MODE   = 12'h020;
  localparam logic [11:0] OFS_STATUS = 12'h024;

  // ***************
  // Fields and reset values
  // ***************
  localparam int unsigned MODE_DOUBLE_BIT = 6;
  localparam int unsigned STAT_HALF_BIT   = 3;
  localparam int unsigned STAT_RUN_BIT    = 0;
  localparam logic [7:0]  SYNCW_RESET     = 8'h27;
  localparam logic [3:0]  WR_ALL          = 4'hf;
  localparam int unsigned WR_PERIOD       = 3;
endpackage : tpw_pkg
`default_nettype wire

// ==== logic/tpw_sync_pulse.sv ====
// Sync pulse stretcher of programmable width
`timescale 1ns/10ps
`default_nettype none
module tpw_sync_pulse
  import tpw_pkg::*;
#(
  parameter int unsigned SW_W = 8
)
(
  input  wire logic            clock,  // Core clock
  input  wire logic            rst_n,  // Async reset
  input  wire logic            fire,   // Start of pulse
  input  wire logic [SW_W-1:0] width,  // Width minus one
  output logic                 pulse   // Sync pulse out
);
  typedef struct packed {
    logic            out;
    logic [SW_W-1:0] cnt;
  } tpw_sp_t;

  tpw_sp_t st;
  tpw_sp_t next_st;

  // [R13] width plus one
  always_comb
  begin
    next_st = st;
    if (fire)
    begin
      next_st.out = 1'b1;
      next_st.cnt = width;
    end
    else if (st.cnt != '0)
      next_st.cnt = st.cnt - 1'b1;
    else
      next_st.out = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulse = st.out;

  // Helper: length of the pulse now high
  logic [SW_W:0] hlen;
  logic [SW_W:0] wlen;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hlen <= '0;
      wlen <= '0;
    end
    else
    begin
      hlen <= fire ? '0 : (st.out ? hlen + 1'b1 : hlen);
      wlen <= fire ? {1'b0, width} + 1'b1 : wlen;
    end
  end

  a_sync_width: assert property ( // [R13]
    @(posedge clock) disable iff (!rst_n)
    $fell(st.out) |-> hlen == wlen)
    else $error("sync pulse width differs from width plus one");
endmodule : tpw_sync_pulse
`default_nettype wire

// ==== logic/tpw_phase_pair.sv ====
// One complementary output pair with dead time
`timescale 1ns/10ps
`default_nettype none
module tpw_phase_pair
  import tpw_pkg::*;
#(
  parameter int unsigned PER_W = 16,
  parameter int unsigned DT_W  = 10
)
(
  input  wire logic             clock,  // Core clock
  input  wire logic             rst_n,  // Async reset
  input  wire logic             run,    // Timer running
  input  wire logic             half,   // Second half
  input  wire logic [PER_W-1:0] cnt,    // Up/down count
  input  wire logic [PER_W-1:0] period, // Half period
  input  wire logic [PER_W-1:0] duty,   // Duty value
  input  wire logic [DT_W-1:0]  dead,   // Dead time
  output logic                  high_n, // High side, low = on
  output logic                  low_n   // Low side, low = on
);
  typedef struct packed {
    logic hi_n;
    logic lo_n;
  } tpw_pp_t;

  tpw_pp_t st;
  tpw_pp_t next_st;
  logic signed [PER_W+2:0] base;
  logic signed [PER_W+2:0] thr_on;
  logic signed [PER_W+2:0] thr_off;
  logic signed [PER_W+2:0] pos;

  // [R4] [R17] symmetric dead gap
  always_comb
  begin
    base    = $signed({3'b000, period}) - $signed({3'b000, duty});
    thr_on  = base + $signed({{(PER_W-DT_W+3){1'b0}}, dead});
    thr_off = base - $signed({{(PER_W-DT_W+3){1'b0}}, dead});
    pos     = $signed({3'b000, cnt});
    next_st = '{hi_n: 1'b1, lo_n: 1'b1};
    // [R15] active low outputs
    if (run && !half)
    begin
      next_st.hi_n = !(pos >= thr_on);
      next_st.lo_n = !(pos < thr_off);
    end
    else if (run)
    begin
      next_st.hi_n = !(pos > thr_on);
      next_st.lo_n = !(pos <= thr_off);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      st <= '{hi_n: 1'b1, lo_n: 1'b1};
    else
      st <= next_st;
  end

  assign high_n = st.hi_n;
  assign low_n  = st.lo_n;

  a_no_overlap: assert property ( // [R4]
    @(posedge clock) disable iff (!rst_n)
    $fell(st.lo_n) && dead != '0 |-> $past(st.hi_n, 2))
    else $error("low side on without dead time after high side");
endmodule : tpw_phase_pair
`default_nettype wire

// ==== logic/tpw_timing_core.sv ====
// Three-phase PWM timing core with APB registers
//
// Behaviour
// [R1] One clock tick; period value is half
// [R2] Period register 16 bits, up to all-ones
// [R3] One 10-bit dead time for pairs
// [R4] Dead gap is twice dead count
// [R5] Dead time zero to 1023, zero allowed
// [R6] Mode bit 6 selects double update
// [R7] Mode bit cleared after reset
// [R8] Single mode: one sync per period
// [R9] Sync edge loads timing working copies
// [R10] Sync edge loads output control copy
// [R11] Double mode adds midpoint sync load
// [R12] Status bit 3 marks second half
// [R13] Sync width is register plus one
// [R14] Sync width resets to 39
// [R15] Outputs active low
// [R16] Idle until period and duties written
// [R17] Dead time shifts both edges equally
// [R18] Interrupt request on every sync
// [R19] Counter up first half, down second
// [R20] Host updates before next sync
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tpw_timing_core
  import tpw_pkg::*;
#(
  parameter int unsigned PER_W = 16,
  parameter int unsigned DT_W  = 10,
  parameter int unsigned SW_W  = 8
)
(
  input  wire logic              clock,            // 125 MHz clock
  input  wire logic              rst_n,            // Async reset
  input  wire logic              psel,             // APB select
  input  wire logic              penable,          // APB enable
  input  wire logic              pwrite,           // APB write
  input  wire logic [ADDR_W-1:0] paddr,            // APB address
  input  wire logic [DATA_W-1:0] pwdata,           // APB write data
  output logic      [DATA_W-1:0] prdata,           // APB read data
  output logic                   pready,           // APB ready
  output logic                   pslverr,          // APB error
  output logic                   phase_a_high_out, // Phase A high
  output logic                   phase_a_low_out,  // Phase A low
  output logic                   phase_b_high_out, // Phase B high
  output logic                   phase_b_low_out,  // Phase B low
  output logic                   phase_c_high_out, // Phase C high
  output logic                   phase_c_low_out,  // Phase C low
  output logic                   period_sync_pulse,// Sync pin
  output logic                   sync_irq,         // Sync request
  output logic                   second_half,      // Half status
  output logic      [OEC_W-1:0]  oec_active,       // Output ctl copy
  output logic      [MPW_W-1:0]  min_pw_active     // Min width copy
);
  // ***************
  // Elaboration checks
  // ***************
  if (PER_W < 2 || PER_W > DATA_W)
    $error("PER_W out of range");
  if (DT_W < 1 || DT_W > PER_W)
    $error("DT_W out of range");
  if (SW_W < 1 || SW_W > PER_W)
    $error("SW_W out of range");

  // ***************
  // State
  // ***************
  typedef struct packed {
    logic [PER_W-1:0]        per;
    logic [DT_W-1:0]         dt;
    logic [MPW_W-1:0]        mpw;
    logic [SW_W-1:0]         sw;
    logic [2:0][PER_W-1:0]   duty;
    logic [OEC_W-1:0]        oec;
    logic                    dbl;
    logic [3:0]              wr;
    logic [PER_W-1:0]        sh_per;
    logic [DT_W-1:0]         sh_dt;
    logic [MPW_W-1:0]        sh_mpw;
    logic [SW_W-1:0]         sh_sw;
    logic [2:0][PER_W-1:0]   sh_duty;
    logic [OEC_W-1:0]        sh_oec;
    logic                    run;
    logic                    half;
    logic [PER_W-1:0]        cnt;
    logic                    fire;
    logic [DATA_W-1:0]       rdata;
  } tpw_core_t;

  tpw_core_t st;
  tpw_core_t next_st;
  logic      wr_en;
  logic      load;
  logic      to_half1;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_PERIOD, OFS_DEAD, OFS_MINPW, OFS_SYNCW,
      OFS_DUTY_A, OFS_DUTY_B, OFS_DUTY_C, OFS_OEC,
      OFS_MODE, OFS_STATUS:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  endfunction : addr_hit

  // ***************
  // APB slave
  // ***************
  // Zero wait states; read data caught in the setup cycle
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign wr_en   = psel & penable & pwrite & addr_hit(paddr);
  assign prdata  = st.rdata;

  always_comb
  begin
    next_st  = st;
    load     = 1'b0;
    to_half1 = 1'b0;
    next_st.fire = 1'b0;
    if (psel && !penable && !pwrite)
    begin
      next_st.rdata = '0;
      case (paddr)
        OFS_PERIOD:
          next_st.rdata[PER_W-1:0] = st.per;
        OFS_DEAD:
          next_st.rdata[DT_W-1:0] = st.dt;
        OFS_MINPW:
          next_st.rdata[MPW_W-1:0] = st.mpw;
        OFS_SYNCW:
          next_st.rdata[SW_W-1:0] = st.sw;
        OFS_DUTY_A:
          next_st.rdata[PER_W-1:0] = st.duty[0];
        OFS_DUTY_B:
          next_st.rdata[PER_W-1:0] = st.duty[1];
        OFS_DUTY_C:
          next_st.rdata[PER_W-1:0] = st.duty[2];
        OFS_OEC:
          next_st.rdata[OEC_W-1:0] = st.oec;
        OFS_MODE:
          next_st.rdata[MODE_DOUBLE_BIT] = st.dbl;
        // [R12] half flag in status
        OFS_STATUS:
        begin
          next_st.rdata[STAT_HALF_BIT] = st.half;
          next_st.rdata[STAT_RUN_BIT]  = st.run;
        end
        default:
          next_st.rdata = '0;
      endcase
    end
    // [R2] [R3] [R5] full-width writes
    if (wr_en)
    begin
      case (paddr)
        OFS_PERIOD:
        begin
          next_st.per = pwdata[PER_W-1:0];
          next_st.wr[WR_PERIOD] = 1'b1;
        end
        OFS_DEAD:
          next_st.dt = pwdata[DT_W-1:0];
        OFS_MINPW:
          next_st.mpw = pwdata[MPW_W-1:0];
        OFS_SYNCW:
          next_st.sw = pwdata[SW_W-1:0];
        OFS_DUTY_A:
        begin
          next_st.duty[0] = pwdata[PER_W-1:0];
          next_st.wr[0] = 1'b1;
        end
        OFS_DUTY_B:
        begin
          next_st.duty[1] = pwdata[PER_W-1:0];
          next_st.wr[1] = 1'b1;
        end
        OFS_DUTY_C:
        begin
          next_st.duty[2] = pwdata[PER_W-1:0];
          next_st.wr[2] = 1'b1;
        end
        OFS_OEC:
          next_st.oec = pwdata[OEC_W-1:0];
        // [R6] update mode select
        OFS_MODE:
          next_st.dbl = pwdata[MODE_DOUBLE_BIT];
        default:
          next_st.dbl = st.dbl;
      endcase
    end

    // ***************
    // Main timer
    // ***************
    // [R16] idle until all four written
    if (!st.run)
    begin
      next_st.cnt  = '0;
      next_st.half = 1'b0;
      if (st.wr == WR_ALL)
      begin
        next_st.run = 1'b1;
        load = 1'b1;
      end
    end
    // [R19] [R1] up count in first half
    else if (!st.half)
    begin
      if ({1'b0, st.cnt} + 1'b1 >= {1'b0, st.sh_per})
      begin
        next_st.half = 1'b1;
        to_half1 = 1'b1;
        // [R11] midpoint load in double mode
        load = st.dbl;
      end
      else
        next_st.cnt = st.cnt + 1'b1;
    end
    // [R19] down count in second half
    else if (st.cnt <= {{(PER_W-1){1'b0}}, 1'b1})
    begin
      next_st.half = 1'b0;
      next_st.cnt  = '0;
      // [R8] one period-start load and sync
      load = 1'b1;
    end
    else
      next_st.cnt = st.cnt - 1'b1;

    // [R9] [R10] working copies at sync
    if (load)
    begin
      next_st.sh_per  = st.per;
      next_st.sh_dt   = st.dt;
      next_st.sh_mpw  = st.mpw;
      next_st.sh_sw   = st.sw;
      next_st.sh_duty = st.duty;
      next_st.sh_oec  = st.oec;
      next_st.fire    = 1'b1;
    end
    if (to_half1)
      next_st.cnt = next_st.sh_per;
  end

  // [R7] [R14] reset values
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st       <= '0;
      st.sw    <= SYNCW_RESET;
      st.sh_sw <= SYNCW_RESET;
    end
    else
      st <= next_st;
  end

  // ***************
  // Sync pulse and outputs
  // ***************
  tpw_sync_pulse #(
    .SW_W  (SW_W)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .fire  (st.fire),
    .width (st.sh_sw),
    .pulse (period_sync_pulse)
  );

  // [R18] one request per sync
  assign sync_irq      = st.fire;
  assign second_half   = st.half;
  assign oec_active    = st.sh_oec;
  assign min_pw_active = st.sh_mpw;

  logic [2:0] hi_n;
  logic [2:0] lo_n;

  for (genvar g = 0; g < 3; g++)
  begin : g_pair
    tpw_phase_pair #(
      .PER_W  (PER_W),
      .DT_W   (DT_W)
    ) u_pair (
      .clock  (clock),
      .rst_n  (rst_n),
      .run    (st.run),
      .half   (st.half),
      .cnt    (st.cnt),
      .period (st.sh_per),
      .duty   (st.sh_duty[g]),
      .dead   (st.sh_dt),
      .high_n (hi_n[g]),
      .low_n  (lo_n[g])
    );
  end

  assign phase_a_high_out = hi_n[0];
  assign phase_a_low_out  = lo_n[0];
  assign phase_b_high_out = hi_n[1];
  assign phase_b_low_out  = lo_n[1];
  assign phase_c_high_out = hi_n[2];
  assign phase_c_low_out  = lo_n[2];

  // ***************
  // Checks
  // ***************
  sequence s_up_step;
    st.run && !st.half && ({1'b0, st.cnt} + 1'b1 < {1'b0, st.sh_per});
  endsequence

  a_up_count: assert property ( // [R19]
    @(posedge clock) disable iff (!rst_n)
    s_up_step |=> st.cnt == $past(st.cnt) + 1'b1)
    else $error("counter did not step up by one");

  a_mode_write: assert property ( // [R6]
    @(posedge clock) disable iff (!rst_n)
    wr_en && paddr == OFS_MODE |=> st.dbl == $past(pwdata[MODE_DOUBLE_BIT]))
    else $error("mode bit not taken from write data");

  a_idle_off: assert property ( // [R16]
    @(posedge clock) disable iff (!rst_n)
    !st.run |=> hi_n == 3'b111 && lo_n == 3'b111 && st.fire == st.run)
    else $error("outputs active before timer runs");

  a_shadow_load: assert property ( // [R9]
    @(posedge clock) disable iff (!rst_n)
    st.fire |-> st.sh_per == $past(st.per) && st.sh_dt == $past(st.dt)
      && st.sh_duty == $past(st.duty) && st.sh_oec == $past(st.oec))
    else $error("working copies not loaded at sync");

  a_single_sync: assert property ( // [R8]
    @(posedge clock) disable iff (!rst_n)
    st.fire && !$past(st.dbl) |-> !st.half && st.cnt == '0)
    else $error("sync outside period start in single mode");

  a_mid_sync: assert property ( // [R11]
    @(posedge clock) disable iff (!rst_n)
    // Mode is taken at the edge that flips the half, not after it
    st.run && $past(st.dbl) && $rose(st.half) |-> st.fire)
    else $error("no midpoint sync in double mode");

  a_half_status: assert property ( // [R12]
    @(posedge clock) disable iff (!rst_n)
    psel && !penable && !pwrite && paddr == OFS_STATUS
      |=> prdata[STAT_HALF_BIT] == $past(st.half))
    else $error("status half bit wrong");

  a_sync_irq: assert property ( // [R18]
    @(posedge clock) disable iff (!rst_n)
    sync_irq |=> period_sync_pulse)
    else $error("sync request without sync pulse");
endmodule : tpw_timing_core
`default_nettype wire

// ==== test/tpw_gate_model.sv ====
// Model of the inverter gate drivers watching the three output pairs
`timescale 1ns/10ps
`default_nettype none
module tpw_gate_model
(
  input  wire logic        clock,    // Core clock
  input  wire logic        rst_n,    // Async reset
  input  wire logic        a_hi_n,   // Phase A high, low = on
  input  wire logic        a_lo_n,   // Phase A low, low = on
  input  wire logic        b_hi_n,   // Phase B high
  input  wire logic        b_lo_n,   // Phase B low
  input  wire logic        c_hi_n,   // Phase C high
  input  wire logic        c_lo_n,   // Phase C low
  output logic      [31:0] gap,      // Last both-off run on A
  output logic      [31:0] hi_on,    // Last high-on run on A
  output logic      [31:0] lo_on,    // Last low-on run on A
  output logic      [31:0] overlaps  // Cycles with a pair both on
);
  logic [1:0]  prev;
  logic [31:0] run;

  // ***************
  // Run lengths of phase A
  // ***************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev     <= 2'h3;
      run      <= 32'h0;
      gap      <= 32'h0;
      hi_on    <= 32'h0;
      lo_on    <= 32'h0;
      overlaps <= 32'h0;
    end
    else
    begin
      if ({a_hi_n, a_lo_n} != prev)
      begin
        case (prev)
          2'h3:    gap   <= run;
          2'h1:    hi_on <= run;
          2'h2:    lo_on <= run;
          default: ;
        endcase
        run <= 32'h1;
      end
      else
        run <= run + 32'h1;
      prev <= {a_hi_n, a_lo_n};
      // A low level turns a switch on; both on shorts the link
      if (!(a_hi_n | a_lo_n) || !(b_hi_n | b_lo_n) || !(c_hi_n | c_lo_n))
        overlaps <= overlaps + 32'h1;
    end
  end
endmodule : tpw_gate_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench of the PWM timing core
`timescale 1ns/10ps
`default_nettype none
module tb
  import tpw_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, err;
  logic        ah, al, bh, bl, ch, cl, sync, irq, half;
  logic [8:0]  oec;
  logic [9:0]  mpw;
  logic [31:0] gap, hi_on, lo_on, ovl, seed = 32'h11ed;
  logic [31:0] irq_gap = 0, irq_cnt = 0, sw_cnt = 0, sync_w = 0;
  logic [31:0] hf_cnt = 0, half_len = 0, n_irq = 0;
  logic [31:0] n, dt, du, sw, eo;
  int          failures = 0, n_compared = 0;

  always #4 clock = ~clock;

  tpw_timing_core DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_high_out(ah), .phase_a_low_out(al), .phase_b_high_out(bh),
    .phase_b_low_out(bl), .phase_c_high_out(ch), .phase_c_low_out(cl),
    .period_sync_pulse(sync), .sync_irq(irq), .second_half(half),
    .oec_active(oec), .min_pw_active(mpw));

  tpw_gate_model gates (.clock(clock), .rst_n(rst_n), .a_hi_n(ah),
    .a_lo_n(al), .b_hi_n(bh), .b_lo_n(bl), .c_hi_n(ch), .c_lo_n(cl),
    .gap(gap), .hi_on(hi_on), .lo_on(lo_on), .overlaps(ovl));

  // ***************
  // Pin monitors
  // ***************
  always @(posedge clock)
  begin
    if (irq === 1'b1)
    begin
      irq_gap = irq_cnt;
      irq_cnt = 1;
      n_irq++;
    end
    else
      irq_cnt++;
    if (sync === 1'b1)
      sw_cnt++;
    else if (sw_cnt != 0)
    begin
      sync_w = sw_cnt;
      sw_cnt = 0;
    end
    if (half === 1'b1)
      hf_cnt++;
    else if (hf_cnt != 0)
    begin
      half_len = hf_cnt;
      hf_cnt = 0;
    end
  end

  // ***************
  // Tasks and functions
  // ***************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected on runs of one pair, in clock cycles
  function automatic logic [31:0] exp_hi(input logic [31:0] c,
                                         input logic [31:0] d);
    return 2 * (c - d);
  endfunction : exp_hi

  function automatic logic [31:0] exp_lo(input logic [31:0] p,
                                         input logic [31:0] c,
                                         input logic [31:0] d);
    return 2 * (p - c - d);
  endfunction : exp_lo

  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask : check_reg

  task automatic check_cnt(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t count got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask : check_cnt

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      failures++;
      test_done();
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_irqs(input int k);
    int i;
    repeat (k)
    begin
      for (i = 0; i < 3000; i++)
      begin
        @(posedge clock);
        if (irq === 1'b1)
          break;
      end
      if (i == 3000)
      begin
        failures++;
        test_done();
      end
    end
  endtask : wait_irqs

  task automatic setup(input logic [31:0] p, input logic [31:0] d,
                       input logic [31:0] c, input logic [31:0] s);
    apb(1'b1, OFS_PERIOD, p);
    apb(1'b1, OFS_DEAD, d);
    apb(1'b1, OFS_SYNCW, s);
    apb(1'b1, OFS_DUTY_A, c);
    apb(1'b1, OFS_DUTY_B, c);
    apb(1'b1, OFS_DUTY_C, c);
  endtask : setup

  // ***************
  // Main sequence
  // ***************
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, OFS_SYNCW, 0);
    check_reg(q, 32'h27);
    apb(1'b0, OFS_MODE, 0);
    check_reg(q, 32'h0);
    apb(1'b0, 12'h3f0, 0);
    check_reg({31'h0, err}, 32'h1);
    apb(1'b1, OFS_PERIOD, 32'hffff);
    apb(1'b0, OFS_PERIOD, 0);
    check_reg(q, 32'hffff);
    apb(1'b1, OFS_DEAD, 32'hffffffff);
    apb(1'b0, OFS_DEAD, 0);
    check_reg(q, 32'h3ff);
    apb(1'b1, OFS_DEAD, 0);
    apb(1'b0, OFS_DEAD, 0);
    check_reg(q, 32'h0);
    repeat (100) @(posedge clock);
    check_cnt(n_irq, 0);
    check_reg({31'h0, ah & al}, 32'h1);
    setup(60, 3, 8, 39);
    wait_irqs(3);
    check_cnt(irq_gap, 120);
    check_cnt(half_len, 60);
    check_cnt(sync_w, 40);
    check_cnt(gap, 6);
    check_cnt(hi_on, exp_hi(8, 3));
    check_cnt(lo_on, exp_lo(60, 8, 3));
    apb(1'b1, OFS_MODE, 32'h40);
    wait_irqs(4);
    check_cnt(irq_gap, 60);
    check_cnt(half_len, 60);
    apb(1'b1, OFS_MODE, 0);
    wait_irqs(3);
    seed = lfsr(seed);
    eo = {23'h0, seed[8:0]};
    // writes land well before next sync
    apb(1'b1, OFS_OEC, eo);
    apb(1'b1, OFS_MINPW, {22'h0, seed[18:9]});
    check_reg({23'h0, oec}, 32'h0);
    wait_irqs(1);
    repeat (2) @(posedge clock);
    check_reg({23'h0, oec}, eo);
    check_reg({22'h0, mpw}, {22'h0, seed[18:9]});
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      n  = 300;
      dt = 1 + seed[15:8] % 50;
      du = dt + 1 + seed[31:16] % (n - 2 * dt - 2);
      sw = (k == 0) ? 0 : (k == 1) ? 32'hff : {24'h0, seed[7:0]};
      setup(n, dt, du, sw);
      wait_irqs(3);
      check_cnt(irq_gap, 2 * n);
      check_cnt(sync_w, sw + 1);
      check_cnt(gap, 2 * dt);
      check_cnt(hi_on, exp_hi(du, dt));
      check_cnt(lo_on, exp_lo(n, du, dt));
    end
    check_cnt(ovl, 0);
    test_done();
  end
endmodule : tb
`default_nettype wire
